// >>> core/rtc_pkg.sv
// Purpose: shared constants and carrier types of the rate/temperature compensation block
// Assumes: registers are addressed by their word index on a plain port
// Notes: coefficient field widths follow the system register layout
package rtc_pkg;

  // ---------------------------------------------------------------
  // register map (word index)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_TCAL = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h3D;
  localparam logic [7:0] OFF_LAST = 8'h48;
  localparam logic [7:0] OFF_BLK_BASE = 8'h3C;
  localparam logic [7:0] OFF_STATUS = 8'h60;

  // word indices inside the system register array
  localparam int IDX_TCAL = 0;
  localparam int IDX_CTRL = 1;
  localparam int IDX_MID = 2;
  localparam int IDX_SCL0 = 3;
  localparam int IDX_BIAS0 = 4;
  localparam int IDX_BIAS1 = 5;
  localparam int IDX_SCL1 = 6;
  localparam int IDX_BIAS2 = 7;
  localparam int IDX_SCL2 = 8;
  localparam int IDX_BIAS3 = 9;
  localparam int IDX_SCL3 = 10;
  localparam int IDX_BIAS4 = 11;
  localparam int IDX_SCL4 = 12;
  localparam int NUM_WORDS = 13;
  localparam int NUM_SLOTS = 5;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int RATE_SEL_BIT = 31;
  localparam int TEMP_SEL_BIT = 3;
  localparam int SLOT_LSB = 8;
  localparam int SLOT_MSB = 12;
  localparam int OFS_LSB = 18;
  localparam int OFS_MSB = 31;
  localparam int GAIN_LSB = 4;
  localparam int GAIN_MSB = 17;
  localparam int W_SCL4 = 19;
  localparam int W_SCL3 = 20;
  localparam int W_SCL2 = 21;
  localparam int W_SCL1 = 30;
  localparam int W_SCL0 = 31;
  localparam int W_BIAS4 = 19;
  localparam int W_BIAS3 = 20;
  localparam int W_BIAS2 = 20;
  localparam int W_BIAS1 = 30;
  localparam int W_BIAS0 = 24;
  localparam int W_MID = 24;

  // ---------------------------------------------------------------
  // reset values and factory image
  // ---------------------------------------------------------------
  localparam logic [4:0] SLOT_DEFAULT = 5'h01;
  localparam logic [4:0] SLOT_FULL = 5'h1F;
  localparam logic [31:0] TCAL_DEFAULT = 32'h0000_8000;
  localparam logic [31:0] CTRL_DEFAULT = 32'h8000_0000;
  localparam logic [31:0] SCL0_RAW_MODE = 32'h0800_0000;

  // ---------------------------------------------------------------
  // arithmetic constants
  // ---------------------------------------------------------------
  localparam int RATE_OUTPUT_SCALE = 10000;
  localparam int TEMP_COUNTS_PER_DEG = 20;
  localparam int TEMP_SCALE_SHIFT = 6;
  localparam int GAIN_FRAC_BITS = 11;
  localparam int SF_NORM_SHIFT = 27;
  localparam int POLY_STEPS = 4;
  localparam int DIV_STEPS = 64;
  // Horner step shifts, from order 3 down to order 0
  localparam logic [6:0] SF_SHIFT0 = 7'h14;
  localparam logic [6:0] SF_SHIFT1 = 7'h11;
  localparam logic [6:0] SF_SHIFT2 = 7'h09;
  localparam logic [6:0] SF_SHIFT3 = 7'h13;
  localparam logic [6:0] B_SHIFT0 = 7'h14;
  localparam logic [6:0] B_SHIFT1 = 7'h15;
  localparam logic [6:0] B_SHIFT2 = 7'h0C;
  localparam logic [6:0] B_SHIFT3 = 7'h14;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_POLY = 2'h1,
    ST_DIV = 2'h3,
    ST_DONE = 2'h2
  } rtc_state_e;

  typedef struct packed {
    logic signed [23:0] rate;
    logic signed [15:0] temp;
  } rtc_sample_s;

  typedef struct packed {
    logic signed [31:0] rate;
    logic signed [31:0] temp;
  } rtc_result_s;

endpackage

// >>> core/rtc_horner_step.sv
// Purpose: one Horner step of a fixed-point polynomial, acc*d rescaled plus next coefficient
// Assumes: shift realigns the accumulator to the next coefficient's scaling
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module rtc_horner_step (
  input wire logic signed [63:0] acc,
  input wire logic signed [31:0] d,
  input wire logic signed [63:0] coef,
  input wire logic [6:0] shift,
  output logic signed [63:0] nxt
);

  // ---------------------------------------------------------------
  // multiply, realign, accumulate
  // ---------------------------------------------------------------
  // full 96-bit product so the shift drops only fraction bits
  logic signed [95:0] prod;
  logic signed [95:0] aligned;
  assign prod = acc * d;
  assign aligned = prod >>> shift;
  assign nxt = coef + aligned[63:0];

endmodule

// >>> core/rtc_core.sv
// Purpose: temperature compensation of rate and temperature plus the coefficient store
// Assumes: one raw sample at a time; samples arriving while busy are dropped
// Notes: the nonvolatile store survives SYS_RST and is cleared only by PWR_ON_RST
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module rtc_core (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PWR_ON_RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic PROG,
  output logic [31:0] RDATA,
  input wire logic SAMPLE_VALID,
  input wire rtc_pkg::rtc_sample_s SAMPLE,
  output logic OUT_VALID,
  output rtc_pkg::rtc_result_s RESULT,
  output logic BUSY
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // sign-extend the low w bits of a register word to 64 bits
  function automatic logic signed [63:0] sext(input logic [31:0] v, input int w);
    logic [63:0] t;
    t = {32'h0000_0000, v} << (64 - w);
    return $signed(t) >>> (64 - w);
  endfunction

  // power-on contents of each coefficient word: raw mode, rate select on
  function automatic logic [31:0] factory_word(input int i);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (i == rtc_pkg::IDX_TCAL) begin
      w = rtc_pkg::TCAL_DEFAULT;
    end else if (i == rtc_pkg::IDX_CTRL) begin
      w = rtc_pkg::CTRL_DEFAULT;
    end else if (i == rtc_pkg::IDX_SCL0) begin
      w = rtc_pkg::SCL0_RAW_MODE;
    end
    return w;
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0] sys_ff [rtc_pkg::NUM_WORDS];
  logic [31:0] nvm_ff [rtc_pkg::NUM_SLOTS * rtc_pkg::NUM_WORDS];
  logic [4:0] nvm_cnt_ff;
  logic prog_err_ff;
  logic [31:0] rdata_ff;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire hit_tcal = (ADDR == rtc_pkg::OFF_TCAL);
  wire hit_blk = (ADDR >= rtc_pkg::OFF_CTRL) && (ADDR <= rtc_pkg::OFF_LAST);
  wire hit_stat = (ADDR == rtc_pkg::OFF_STATUS);
  wire hit_sys = hit_tcal || hit_blk;
  wire [7:0] blk_off = ADDR - rtc_pkg::OFF_BLK_BASE;
  wire [3:0] idx = hit_tcal ? 4'h0 : blk_off[3:0];

  // thermometer count of programmed slots; next free slot = count
  wire [2:0] used = (nvm_cnt_ff == rtc_pkg::SLOT_FULL) ? 3'h5 :
                    nvm_cnt_ff[3] ? 3'h4 : nvm_cnt_ff[2] ? 3'h3 :
                    nvm_cnt_ff[1] ? 3'h2 : nvm_cnt_ff[0] ? 3'h1 : 3'h0;
  wire [2:0] active = (used == 3'h0) ? 3'h0 : used - 3'h1;
  wire slots_full = (used == 3'h5);
  wire [4:0] slot_req = sys_ff[rtc_pkg::IDX_CTRL][rtc_pkg::SLOT_MSB:rtc_pkg::SLOT_LSB];
  wire slot_ok = (slot_req == {nvm_cnt_ff[3:0], 1'b1});
  wire prog_hit = PROG && hit_sys;
  wire prog_ok = prog_hit && !slots_full && ((idx != 4'h1) || slot_ok);
  wire [6:0] prog_base = 7'(used) * 7'(rtc_pkg::NUM_WORDS);
  wire [6:0] load_base = 7'(active) * 7'(rtc_pkg::NUM_WORDS);

  // ---------------------------------------------------------------
  // nonvolatile store
  // ---------------------------------------------------------------
  // a burn lands in the next free slot, so earlier sets stay untouched but unused
  always_ff @(posedge CLK) begin
    if (PWR_ON_RST) begin
      for (int i = 0; i < rtc_pkg::NUM_SLOTS * rtc_pkg::NUM_WORDS; i++) begin
        nvm_ff[i] <= (i < rtc_pkg::NUM_WORDS) ? factory_word(i) : 32'h0000_0000;
      end
      nvm_cnt_ff <= rtc_pkg::SLOT_DEFAULT;
    end else if (prog_ok) begin
      nvm_ff[prog_base + 7'(idx)] <= sys_ff[idx];
      if (idx == 4'h1) begin
        nvm_cnt_ff <= slot_req;
      end
    end
  end

  // ---------------------------------------------------------------
  // system registers
  // ---------------------------------------------------------------
  // reload from the active slot on every system reset
  always_ff @(posedge CLK) begin
    if (PWR_ON_RST) begin
      for (int i = 0; i < rtc_pkg::NUM_WORDS; i++) begin
        sys_ff[i] <= factory_word(i);
      end
      sys_ff[rtc_pkg::IDX_CTRL][rtc_pkg::SLOT_MSB:rtc_pkg::SLOT_LSB] <= rtc_pkg::SLOT_DEFAULT;
    end else if (SYS_RST) begin
      for (int i = 0; i < rtc_pkg::NUM_WORDS; i++) begin
        sys_ff[i] <= nvm_ff[load_base + 7'(i)];
      end
      sys_ff[rtc_pkg::IDX_CTRL][rtc_pkg::SLOT_MSB:rtc_pkg::SLOT_LSB] <= nvm_cnt_ff;
    end else if (WR && hit_sys) begin
      sys_ff[idx] <= WDATA;
    end
  end

  // refused burns leave a sticky flag; a new refusal beats a clear
  wire nxt_prog_err = (prog_hit && !prog_ok) ||
                      (prog_err_ff && !(WR && hit_stat && WDATA[1]));
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      prog_err_ff <= 1'b0;
    end else begin
      prog_err_ff <= nxt_prog_err;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  wire [31:0] stat_word = {25'h0, used, 2'h0, prog_err_ff, BUSY};
  wire [31:0] rd_mux = hit_sys ? sys_ff[idx] : hit_stat ? stat_word : 32'h0000_0000;
  wire [31:0] nxt_rdata = RD ? rd_mux : 32'h0000_0000;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign RDATA = rdata_ff;

  // ---------------------------------------------------------------
  // coefficient fields
  // ---------------------------------------------------------------
  wire rate_comp_select = sys_ff[rtc_pkg::IDX_CTRL][rtc_pkg::RATE_SEL_BIT];
  wire temp_calib_select = sys_ff[rtc_pkg::IDX_TCAL][rtc_pkg::TEMP_SEL_BIT];
  wire [13:0] temp_offset = sys_ff[rtc_pkg::IDX_TCAL][rtc_pkg::OFS_MSB:rtc_pkg::OFS_LSB];
  wire [13:0] temp_gain = sys_ff[rtc_pkg::IDX_TCAL][rtc_pkg::GAIN_MSB:rtc_pkg::GAIN_LSB];
  wire [23:0] temp_midpoint = sys_ff[rtc_pkg::IDX_MID][23:0];
  // the output scale is already divided into every scale coefficient
  wire signed [63:0] scale_coef_4 = sext(sys_ff[rtc_pkg::IDX_SCL4], rtc_pkg::W_SCL4);
  wire signed [63:0] scale_coef_3 = sext(sys_ff[rtc_pkg::IDX_SCL3], rtc_pkg::W_SCL3);
  wire signed [63:0] scale_coef_2 = sext(sys_ff[rtc_pkg::IDX_SCL2], rtc_pkg::W_SCL2);
  wire signed [63:0] scale_coef_1 = sext(sys_ff[rtc_pkg::IDX_SCL1], rtc_pkg::W_SCL1);
  wire signed [63:0] scale_coef_0 = sext(sys_ff[rtc_pkg::IDX_SCL0], rtc_pkg::W_SCL0);
  wire signed [63:0] bias_coef_4 = sext(sys_ff[rtc_pkg::IDX_BIAS4], rtc_pkg::W_BIAS4);
  wire signed [63:0] bias_coef_3 = sext(sys_ff[rtc_pkg::IDX_BIAS3], rtc_pkg::W_BIAS3);
  wire signed [63:0] bias_coef_2 = sext(sys_ff[rtc_pkg::IDX_BIAS2], rtc_pkg::W_BIAS2);
  wire signed [63:0] bias_coef_1 = sext(sys_ff[rtc_pkg::IDX_BIAS1], rtc_pkg::W_BIAS1);
  wire signed [63:0] bias_coef_0 = sext(sys_ff[rtc_pkg::IDX_BIAS0], rtc_pkg::W_BIAS0);

  // ---------------------------------------------------------------
  // datapath state
  // ---------------------------------------------------------------
  rtc_pkg::rtc_state_e state_ff;
  rtc_pkg::rtc_state_e nxt_state;
  rtc_pkg::rtc_sample_s smp_ff;
  rtc_pkg::rtc_result_s res_ff;
  logic signed [31:0] dt_ff;
  logic signed [63:0] hs_ff;
  logic signed [63:0] hb_ff;
  logic [6:0] step_ff;
  logic [63:0] rem_ff;
  logic [63:0] quo_ff;
  logic [63:0] den_ff;
  logic neg_ff;
  logic valid_ff;

  // temperature variable relative to the midpoint
  wire signed [31:0] t_scaled = 32'(SAMPLE.temp) <<< rtc_pkg::TEMP_SCALE_SHIFT;
  wire signed [31:0] nxt_dt = t_scaled - $signed({8'h00, temp_midpoint});

  // coefficient and realignment for the current Horner step
  wire [1:0] ps = step_ff[1:0];
  wire signed [63:0] sf_c = (ps == 2'h0) ? scale_coef_3 : (ps == 2'h1) ? scale_coef_2 :
                            (ps == 2'h2) ? scale_coef_1 : scale_coef_0;
  wire signed [63:0] b_c = (ps == 2'h0) ? bias_coef_3 : (ps == 2'h1) ? bias_coef_2 :
                           (ps == 2'h2) ? bias_coef_1 : bias_coef_0;
  wire [6:0] sf_sh = (ps == 2'h0) ? rtc_pkg::SF_SHIFT0 : (ps == 2'h1) ? rtc_pkg::SF_SHIFT1 :
                     (ps == 2'h2) ? rtc_pkg::SF_SHIFT2 : rtc_pkg::SF_SHIFT3;
  wire [6:0] b_sh = (ps == 2'h0) ? rtc_pkg::B_SHIFT0 : (ps == 2'h1) ? rtc_pkg::B_SHIFT1 :
                    (ps == 2'h2) ? rtc_pkg::B_SHIFT2 : rtc_pkg::B_SHIFT3;
  logic signed [63:0] hs_nxt;
  logic signed [63:0] hb_nxt;

  rtc_horner_step u_sf_step (
    .acc(hs_ff),
    .d(dt_ff),
    .coef(sf_c),
    .shift(sf_sh),
    .nxt(hs_nxt)
  );

  rtc_horner_step u_bias_step (
    .acc(hb_ff),
    .d(dt_ff),
    .coef(b_c),
    .shift(b_sh),
    .nxt(hb_nxt)
  );

  // numerator (raw - bias) * 2^27, divided by scale term carrying 2^27 too
  wire signed [63:0] diff_r = 64'(smp_ff.rate) - hb_nxt;
  wire [63:0] num_mag = diff_r[63] ? 64'(-diff_r) : 64'(diff_r);
  wire [63:0] num_sh = num_mag << rtc_pkg::SF_NORM_SHIFT;
  wire [63:0] den_mag = hs_nxt[63] ? 64'(-hs_nxt) : 64'(hs_nxt);
  // restoring division, one quotient bit per clock
  wire [64:0] rem_try = {rem_ff, quo_ff[63]};
  wire rem_fit = (rem_try >= {1'b0, den_ff});
  wire [64:0] rem_sub = rem_try - {1'b0, den_ff};
  wire [63:0] nxt_rem = rem_fit ? rem_sub[63:0] : rem_try[63:0];
  wire [63:0] nxt_quo = {quo_ff[62:0], rem_fit};
  wire last_poly = (step_ff == 7'(rtc_pkg::POLY_STEPS - 1));
  wire last_div = (step_ff == 7'(rtc_pkg::DIV_STEPS - 1));
  wire [31:0] quo_lo = quo_ff[31:0];
  wire signed [31:0] rate_cal = neg_ff ? 32'(-quo_lo) : quo_lo;
  wire signed [31:0] rate_res = rate_comp_select ? rate_cal : 32'(smp_ff.rate);
  // gain carries 11 fraction bits; offset is in output counts of 20 per degree
  wire signed [47:0] t_prod = $signed({1'b0, temp_gain}) * smp_ff.temp;
  wire signed [47:0] t_gain = t_prod >>> rtc_pkg::GAIN_FRAC_BITS;
  wire signed [47:0] t_cal = t_gain - $signed({34'h0, temp_offset});
  wire signed [31:0] temp_res = temp_calib_select ? t_cal[31:0] : 32'(smp_ff.temp);

  // next-state: idle, four Horner steps, 64 division steps, result
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rtc_pkg::ST_IDLE: begin
        if (SAMPLE_VALID) begin
          nxt_state = rtc_pkg::ST_POLY;
        end
      end
      rtc_pkg::ST_POLY: begin
        if (last_poly) begin
          nxt_state = rtc_pkg::ST_DIV;
        end
      end
      rtc_pkg::ST_DIV: begin
        if (last_div) begin
          nxt_state = rtc_pkg::ST_DONE;
        end
      end
      default: begin
        nxt_state = rtc_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencing registers; sample is latched only when idle
  always_ff @(posedge CLK) begin
    if (SYS_RST || PWR_ON_RST) begin
      state_ff <= rtc_pkg::ST_IDLE;
      step_ff <= 7'h00;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= (state_ff != nxt_state) ? 7'h00 : step_ff + 7'h01;
      valid_ff <= (state_ff == rtc_pkg::ST_DONE);
    end
  end

  // arithmetic registers
  always_ff @(posedge CLK) begin
    if (state_ff == rtc_pkg::ST_IDLE && SAMPLE_VALID) begin
      smp_ff <= SAMPLE;
      dt_ff <= nxt_dt;
      hs_ff <= scale_coef_4;
      hb_ff <= bias_coef_4;
    end else if (state_ff == rtc_pkg::ST_POLY) begin
      hs_ff <= hs_nxt;
      hb_ff <= hb_nxt;
      if (last_poly) begin
        rem_ff <= 64'h0000_0000_0000_0000;
        quo_ff <= num_sh;
        den_ff <= den_mag;
        neg_ff <= diff_r[63] ^ hs_nxt[63];
      end
    end else if (state_ff == rtc_pkg::ST_DIV) begin
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
    end else if (state_ff == rtc_pkg::ST_DONE) begin
      res_ff.rate <= rate_res;
      res_ff.temp <= temp_res;
    end
  end

  assign OUT_VALID = valid_ff;
  assign RESULT = valid_ff ? res_ff : '0;
  assign BUSY = (state_ff != rtc_pkg::ST_IDLE);

endmodule

// >>> tb/rtc_core_sva.sv
// Purpose: port-level checks of the compensation core
// Assumes: bound to rtc_core from the bench top file; one clock domain
// Notes: sample latency is the fixed 70-cycle figure of the core
`timescale 1ns/1ps
module rtc_core_sva (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PWR_ON_RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic PROG,
  input wire logic [31:0] RDATA,
  input wire logic SAMPLE_VALID,
  input wire rtc_pkg::rtc_sample_s SAMPLE,
  input wire logic OUT_VALID,
  input wire rtc_pkg::rtc_result_s RESULT,
  input wire logic BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST || PWR_ON_RST);
  // -----------------------------------------------------------
  // decodes
  // -----------------------------------------------------------
  wire take = SAMPLE_VALID && !BUSY;
  wire rd_ctrl = RD && (ADDR == rtc_pkg::OFF_CTRL);
  wire rd_tcal = RD && (ADDR == rtc_pkg::OFF_TCAL);
  // -----------------------------------------------------------
  // sample stream
  // -----------------------------------------------------------
  sample_latency_a: assert property (take |-> ##70 OUT_VALID)
    else $error("result not on time");
  busy_hold_a: assert property (take |=> BUSY [*8])
    else $error("busy dropped early");
  out_single_a: assert property (OUT_VALID |=> !OUT_VALID)
    else $error("result longer than one cycle");
  out_idle_a: assert property (OUT_VALID |-> !BUSY)
    else $error("busy during result");
  result_zero_a: assert property (!OUT_VALID |-> RESULT == '0)
    else $error("result not zero when idle");
  // -----------------------------------------------------------
  // register port
  // -----------------------------------------------------------
  rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside read answer");
  slot_code_a: assert property (rd_ctrl |=> RDATA[12:8] inside {5'h00, 5'h01, 5'h03,
    5'h07, 5'h0F, 5'h1F})
    else $error("slot counter not thermometer");
  ctrl_readback_a: assert property ((WR && ADDR == rtc_pkg::OFF_CTRL) ##2 rd_ctrl
    |=> RDATA == $past(WDATA, 3))
    else $error("control word readback wrong");
  tcal_readback_a: assert property (rd_tcal && $past(WR && ADDR == rtc_pkg::OFF_TCAL, 2)
    |=> RDATA == $past(WDATA, 3))
    else $error("temperature word readback wrong");
  // main scenarios seen
  cover property (take);
  cover property (take && OUT_VALID);
  cover property (PROG && ADDR == rtc_pkg::OFF_CTRL);
endmodule

// >>> tb/rtc_host_model.sv
// Purpose: host side of the register and programming port
// Assumes: strobes are one cycle, changed right after a rising edge
// Notes: each task ends with an idle edge so a strobe is never set twice in one step
`timescale 1ns/1ps
module rtc_host_model (
  input wire logic CLK,
  input wire logic [31:0] RDATA,
  output logic [7:0] ADDR,
  output logic [31:0] WDATA,
  output logic WR,
  output logic RD,
  output logic PROG
);
  // burn order: scale 4..0, bias 4..0, midpoint
  localparam logic [7:0] BURN_ORDER [11] = '{8'h48, 8'h46, 8'h44, 8'h42, 8'h3F, 8'h47, 8'h45,
    8'h43, 8'h41, 8'h40, 8'h3E};
  initial begin
    ADDR = 8'h00;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    PROG = 1'b0;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task prog(input logic [7:0] a);
    ADDR <= a;
    PROG <= 1'b1;
    @(posedge CLK);
    PROG <= 1'b0;
    @(posedge CLK);
  endtask
  // answer stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    d = RDATA;
  endtask
  // without commit the slot counter is left alone, so the set must not take effect
  task prog_set(input logic [31:0] v [11], input bit commit);
    logic [31:0] c;
    rd(rtc_pkg::OFF_CTRL, c);
    for (int i = 0; i < 11; i++) begin
      wr(BURN_ORDER[i], v[i]);
      prog(BURN_ORDER[i]);
    end
    if (commit) begin
      rd(rtc_pkg::OFF_CTRL, c);
      c[12:8] = {c[11:8], 1'b1};
      wr(rtc_pkg::OFF_CTRL, c);
      prog(rtc_pkg::OFF_CTRL);
    end
  endtask
endmodule

// >>> tb/rate_temp_compensation_bench.sv
// Purpose: self-checking bench of the compensation core
// Assumes: host model drives the register port, the bench drives samples
// Notes: seeded xorshift keeps runs repeatable
`timescale 1ns/1ps
module rate_temp_compensation_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por = 1'b1;
  logic sv = 1'b0;
  logic ov, busy, wr, rd, prog;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [31:0] seed = 32'h074D;
  logic [31:0] v [11];
  rtc_pkg::rtc_sample_s smp = '0;
  rtc_pkg::rtc_result_s res;
  int bad_count = 0;
  int check_count = 0;
  longint b0v = 0, tmv = 0, sfdiv = 1, toff = 0, tgain = 0;
  bit comp_on = 0, rate_on = 1, tsel = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  rtc_host_model host (.CLK(clk), .RDATA(rdata), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .PROG(prog));
  rtc_core DUT (.CLK(clk), .SYS_RST(sys_rst), .PWR_ON_RST(por), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .PROG(prog), .RDATA(rdata), .SAMPLE_VALID(sv), .SAMPLE(smp),
    .OUT_VALID(ov), .RESULT(res), .BUSY(busy));
  // -----------------------------------------------------------
  // expectations and checks
  // -----------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function longint exp_rate(longint r, longint t);
    longint bias;
    bias = comp_on ? t * 64 - tmv + b0v : 0;
    return rate_on ? (r - bias) / sfdiv : r;
  endfunction
  function longint exp_temp(longint t);
    return tsel ? ((tgain * t) >>> 11) - toff : t;
  endfunction
  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t read %h want %h", $time, g, e);
    end
  endtask
  task chk_out(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t result %h want %h", $time, g, e);
    end
  endtask
  task finish_test();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a second sample offered while busy must be dropped
  task run_sample(input logic signed [23:0] r, input logic signed [15:0] t);
    int n;
    smp <= '{rate: r, temp: t};
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    repeat (5) @(posedge clk);
    chk_out({31'h0, busy}, 32'h1);
    smp <= '{rate: ~r, temp: t};
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    n = 0;
    while (ov !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk_out({31'h0, ov}, 32'h1);
    chk_out(res.rate, 32'(exp_rate(r, t)));
    chk_out(res.temp, 32'(exp_temp(t)));
  endtask
  task do_rst();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask
  task rnd_samples(input int k);
    for (int i = 0; i < k; i++) begin
      got = rnd();
      run_sample(got[23:0], got[31:16]);
    end
  endtask
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    host.rd(rtc_pkg::OFF_TCAL, got);
    chk_reg(got, rtc_pkg::TCAL_DEFAULT);
    host.rd(rtc_pkg::OFF_CTRL, got);
    chk_reg(got, 32'h8000_0100);
    host.rd(8'h3F, got);
    chk_reg(got, rtc_pkg::SCL0_RAW_MODE);
    host.wr(8'h10, 32'hFFFF_FFFF);
    host.rd(8'h10, got);
    chk_reg(got, 32'h0);
    run_sample(24'sh7FFFFF, 16'sh7FFF);
    run_sample(24'sh800000, 16'sh8000);
    rnd_samples(3);
    v = '{default: 32'h0};
    v[4] = rtc_pkg::SCL0_RAW_MODE;
    v[8] = 32'h0010_0000;
    got = rnd();
    v[9] = {{12{got[19]}}, got[19:0]};
    v[10] = {12'h000, got[31:12]};
    host.prog_set(v, 1'b0);
    do_rst();
    host.rd(8'h41, got);
    chk_reg(got, 32'h0);
    host.prog_set(v, 1'b1);
    do_rst();
    host.rd(8'h41, got);
    chk_reg(got, v[8]);
    comp_on = 1;
    b0v = longint'(signed'(v[9]));
    tmv = v[10];
    rnd_samples(4);
    got = rnd();
    tgain = 1024 + got[11:0];
    toff = got[28:16];
    tsel = 1;
    host.wr(rtc_pkg::OFF_TCAL, {toff[13:0], tgain[13:0], 4'h8});
    host.rd(rtc_pkg::OFF_TCAL, got);
    chk_reg(got, {toff[13:0], tgain[13:0], 4'h8});
    rnd_samples(3);
    host.wr(8'h3F, 32'h1000_0000);
    sfdiv = 2;
    rnd_samples(3);
    host.wr(rtc_pkg::OFF_CTRL, 32'h0000_0300);
    host.rd(rtc_pkg::OFF_CTRL, got);
    chk_reg(got, 32'h0000_0300);
    rate_on = 0;
    rnd_samples(2);
    for (int i = 0; i < 3; i++) begin
      host.prog_set(v, 1'b1);
      do_rst();
    end
    host.rd(rtc_pkg::OFF_CTRL, got);
    chk_reg({27'h0, got[12:8]}, 32'h1F);
    host.prog(rtc_pkg::OFF_CTRL);
    host.rd(rtc_pkg::OFF_STATUS, got);
    chk_reg({31'h0, got[1]}, 32'h1);
    host.wr(rtc_pkg::OFF_STATUS, 32'h0000_0002);
    host.rd(rtc_pkg::OFF_STATUS, got);
    chk_reg(got, 32'h0000_0050);
    finish_test();
  end
  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule
bind rtc_core rtc_core_sva chk (.CLK(CLK), .SYS_RST(SYS_RST), .PWR_ON_RST(PWR_ON_RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .PROG(PROG), .RDATA(RDATA),
  .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE(SAMPLE), .OUT_VALID(OUT_VALID), .RESULT(RESULT),
  .BUSY(BUSY));
